// ==== hdl/mrc_pkg.sv ====
// Package for the RTU check-code engine: constants and shared types.
// Assumes one clock domain; used by the engine and its shift core.
package mrc_pkg;
   localparam int MRC_CRC_W = 16;
   localparam int MRC_BYTE_W = 8;
   localparam logic [15:0] MRC_PRESET = 16'hFFFF;
   localparam logic [15:0] MRC_POLY = 16'hA001;
   localparam logic [3:0] MRC_SHIFTS = 4'h8;
   localparam logic [3:0] MRC_SHIFT_ZERO = 4'h0;
   localparam logic [3:0] MRC_SHIFT_ONE = 4'h1;
   localparam logic [1:0] MRC_RX_CRC_BYTES = 2'h2;

   typedef enum logic [1:0] {
      MRC_IDLE = 2'b00,
      MRC_SHIFT = 2'b01,
      MRC_CRC_LO = 2'b11,
      MRC_CRC_HI = 2'b10
   } mrc_state_t;
endpackage

// ==== hdl/mrc_shift_if.sv ====
// Interface between the engine and its shift core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface mrc_shift_if;
   logic [15:0] acc_in;
   logic [15:0] acc_out;
   modport engine (output acc_in, input acc_out);
   modport core (input acc_in, output acc_out);
endinterface

// ==== hdl/mrc_shift_core.sv ====
// One conditional shift step of the reflected CRC-16.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module mrc_shift_core
   import mrc_pkg::*;
(
   mrc_shift_if.core sif
);
   always_comb begin
      if (sif.acc_in[0]) begin
         sif.acc_out = (sif.acc_in >> 1) ^ MRC_POLY;
      end else begin
         sif.acc_out = sif.acc_in >> 1;
      end
   end
endmodule

// ==== hdl/mrc_engine.sv ====
// Check-code engine for RTU frames: byte stream in, CRC out or checked.
// Assumes bytes and strobes come from logic on the same clock.
// Assumes pkt_start opens every frame before its first byte.
//
// Behaviour
// - Check runs only for packets started while the RTU mode input is high.
// - Two-byte result, updated once per eight-bit byte in the range.
// - Accumulator preset to all ones at the start of each packet.
// - First byte XORed into the low byte; upper byte untouched.
// - Shift right one; XOR with A001 when the dropped bit was one.
// - Exactly eight shift steps per byte before the next is taken.
// - Next byte XORed in after the shifts; last byte leaves final CRC.
// - CRC goes out low byte first, received one read in that order.
// - Only elements between start and end index enter the calculation.
`timescale 1ns/1ps
module mrc_engine
   import mrc_pkg::*;
#(
   parameter int IDX_W = 8
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rtu_mode,
   input wire logic pkt_start,
   input wire logic [IDX_W-1:0] range_first,
   input wire logic [IDX_W-1:0] range_last,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic pkt_end,
   input wire logic rx_mode,
   input wire logic crc_emit,
   output logic byte_ready,
   output logic [15:0] crc_value,
   output logic crc_out_valid,
   output logic [7:0] crc_out_byte,
   output logic check_done,
   output logic check_err
);
   // Refused at elaboration: too narrow to index a frame, and wider
   // compares buy nothing at serial byte rates
   if (IDX_W < 2 || IDX_W > 16) begin : g_idx_w_check
      $error("IDX_W out of range");
   end

   // Index sticks at its top value, so an overlong frame cannot wrap
   // back into the range
   localparam logic [IDX_W-1:0] IDX_LAST = '1;

   typedef struct packed {
      // Accumulator and shift sequencing
      mrc_state_t st;
      logic [15:0] acc;
      logic [3:0] nshift;
      logic [IDX_W-1:0] idx;
      logic active;
      // Check bytes taken from the line
      logic [1:0] rx_cnt;
      logic [15:0] rx_crc;
      // Fields that drive the outputs
      logic rdy;
      logic ovalid;
      logic [7:0] obyte;
      logic done;
      logic err;
   } mrc_regs_t;

   mrc_regs_t s_reg;
   mrc_regs_t s_next;
   mrc_shift_if sif ();

   mrc_shift_core u_core (
      .sif(sif.core)
   );

   assign sif.acc_in = s_reg.acc;

   // Request decode; the case below gives them this priority
   logic in_range;
   logic past_range;
   logic take_byte;
   logic rx_crc_byte;
   logic rx_first;
   logic end_check;
   logic emit_go;
   logic shift_last;
   logic crc_match;
   logic [15:0] acc_mixed;

   assign in_range = (s_reg.idx >= range_first) &&
                     (s_reg.idx <= range_last);
   assign past_range = s_reg.idx > range_last;

   // Nothing is taken in an inactive packet: non-RTU frames skip
   assign take_byte = byte_valid && s_reg.rdy && s_reg.active;
   assign rx_crc_byte = rx_mode && past_range &&
                        (s_reg.rx_cnt != MRC_RX_CRC_BYTES);
   assign rx_first = (s_reg.rx_cnt == 2'b00);
   assign end_check = pkt_end && s_reg.active;
   assign emit_go = crc_emit && !rx_mode;
   assign shift_last = s_reg.nshift == (MRC_SHIFTS - MRC_SHIFT_ONE);

   // Low byte only, high byte kept
   assign acc_mixed = {s_reg.acc[15:8], s_reg.acc[7:0] ^ byte_data};
   // A frame cut short of its check pair never matches
   assign crc_match = (s_reg.rx_cnt == MRC_RX_CRC_BYTES) &&
                      (s_reg.rx_crc == s_reg.acc);

   always_comb begin
      s_next = s_reg;
      s_next.ovalid = 1'b0;
      s_next.done = 1'b0;

      // Start of packet overrides any request in the same cycle
      if (pkt_start) begin
         s_next.acc = MRC_PRESET;
         s_next.idx = '0;
         s_next.active = rtu_mode;
         s_next.st = MRC_IDLE;
         s_next.rdy = 1'b1;

         // Capture and verdict of the previous frame are dropped
         s_next.rx_cnt = 2'b00;
         s_next.rx_crc = '0;
         s_next.err = 1'b0;
      end else begin
         case (s_reg.st)
            MRC_IDLE: begin
               if (take_byte) begin
                  if (s_reg.idx != IDX_LAST) begin
                     s_next.idx = s_reg.idx + 1'b1;
                  end
                  // Bytes before the range, or past the check pair, drop
                  if (in_range) begin
                     s_next.acc = acc_mixed;
                     s_next.nshift = MRC_SHIFT_ZERO;
                     s_next.st = MRC_SHIFT;
                     s_next.rdy = 1'b0;
                  end else if (rx_crc_byte) begin
                     // Received CRC, low byte arrives first
                     if (rx_first) begin
                        s_next.rx_crc[7:0] = byte_data;
                     end else begin
                        s_next.rx_crc[15:8] = byte_data;
                     end
                     s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                  end
               end else if (end_check) begin
                  if (rx_mode) begin
                     s_next.done = 1'b1;
                     s_next.err = !crc_match;
                  end
                  s_next.active = 1'b0;
               end else if (emit_go) begin
                  s_next.st = MRC_CRC_LO;
                  s_next.rdy = 1'b0;
               end
            end

            // One step per clock; byte_ready stays low meanwhile
            MRC_SHIFT: begin
               s_next.acc = sif.acc_out;
               s_next.nshift = s_reg.nshift + MRC_SHIFT_ONE;
               if (shift_last) begin
                  s_next.st = MRC_IDLE;
                  s_next.rdy = 1'b1;
               end
            end

            // Low byte goes onto the line first
            MRC_CRC_LO: begin
               s_next.ovalid = 1'b1;
               s_next.obyte = s_reg.acc[7:0];
               s_next.st = MRC_CRC_HI;
            end

            MRC_CRC_HI: begin
               s_next.ovalid = 1'b1;
               s_next.obyte = s_reg.acc[15:8];
               s_next.st = MRC_IDLE;
               s_next.rdy = 1'b1;
            end

            // Unused code: back to idle, data kept
            default: begin
               s_next.st = MRC_IDLE;
            end
         endcase
      end
   end

   // Reset leaves the packet inactive until the first pkt_start
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '{
            st: MRC_IDLE,
            acc: MRC_PRESET,
            nshift: MRC_SHIFT_ZERO,
            idx: '0,
            active: 1'b0,
            rx_cnt: 2'b00,
            rx_crc: '0,
            rdy: 1'b1,
            ovalid: 1'b0,
            obyte: '0,
            done: 1'b0,
            err: 1'b0
         };
      end else begin
         s_reg <= s_next;
      end
   end

   // Read crc_value only while byte_ready is high
   assign byte_ready = s_reg.rdy;
   assign crc_value = s_reg.acc;
   assign crc_out_valid = s_reg.ovalid;
   assign crc_out_byte = s_reg.obyte;
   assign check_done = s_reg.done;
   assign check_err = s_reg.err;
endmodule

// ==== tb/mrc_engine_sva.sv ====
// Port checker for the check-code engine.
// Assumes it is bound onto mrc_engine; one clock domain.
`timescale 1ns/1ps
module mrc_engine_sva (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pkt_start,
   input wire logic byte_valid,
   input wire logic pkt_end,
   input wire logic rx_mode,
   input wire logic crc_emit,
   input wire logic byte_ready,
   input wire logic crc_out_valid,
   input wire logic check_done,
   input wire logic check_err,
   input wire logic [15:0] crc_value,
   input wire logic [7:0] crc_out_byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_pre; pkt_start |=> crc_value == 16'hFFFF; endproperty
   a_pre: assert property (p_pre) else $error("no preset");
   property p_shift; byte_valid && byte_ready && !pkt_start ##1 !byte_ready
      |-> !byte_ready[*8] ##1 byte_ready; endproperty
   a_shift: assert property (p_shift) else $error("shift count");
   property p_hold; byte_ready && !byte_valid && !pkt_start
      |=> $stable(crc_value); endproperty
   a_hold: assert property (p_hold) else $error("crc moved");
   property p_emit; crc_emit && byte_ready && !rx_mode && !pkt_start
      |-> ##2 crc_out_valid
      && crc_out_byte == crc_value[7:0] ##1 crc_out_valid
      && crc_out_byte == crc_value[15:8]; endproperty
   a_emit: assert property (p_emit) else $error("emit order");
   property p_done; pkt_end && rx_mode && byte_ready && !pkt_start
      |=> check_done; endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_cause; check_done |-> $past(pkt_end); endproperty
   a_cause: assert property (p_cause) else $error("stray done");
   property p_err; check_err && !pkt_start |=> check_err; endproperty
   a_err: assert property (p_err) else $error("err dropped");
   property p_clr; pkt_start |=> !check_err; endproperty
   a_clr: assert property (p_clr) else $error("err kept");
   cover property (check_err);
   cover property (crc_out_valid);
   cover property (!byte_ready);
endmodule

// ==== tb/mrc_link_model.sv ====
// Far-end receiver model: assembles the two emitted check bytes.
// Assumes one-cycle byte strobes on the engine clock.
`timescale 1ns/1ps
module mrc_link_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic crc_out_valid,
   input wire logic [7:0] crc_out_byte,
   output logic [15:0] link_crc
);
   // Low byte arrives first, so it ends in the lower half
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) link_crc <= 16'h0000;
      else if (crc_out_valid) link_crc <= {crc_out_byte, link_crc[15:8]};
   end
endmodule

// ==== tb/tb_mrc_engine.sv ====
// Bench for the check-code engine: send, range, receive and mode cases.
// Assumes engine, checker and link model on one 25 MHz clock.
`timescale 1ns/1ps
bind mrc_engine mrc_engine_sva u_sva (
   .clk(clk),
   .arst_n(arst_n),
   .pkt_start(pkt_start),
   .byte_valid(byte_valid),
   .pkt_end(pkt_end),
   .rx_mode(rx_mode),
   .crc_emit(crc_emit),
   .byte_ready(byte_ready),
   .crc_out_valid(crc_out_valid),
   .check_done(check_done),
   .check_err(check_err),
   .crc_value(crc_value),
   .crc_out_byte(crc_out_byte)
);
module tb_mrc_engine;
   logic clk = 0, arst_n = 0, rtu_mode = 1, pkt_start = 0, byte_valid = 0;
   logic pkt_end = 0, rx_mode = 0, crc_emit = 0, byte_ready, crc_out_valid;
   logic check_done, check_err;
   logic [7:0] range_first = 0, range_last = 1, byte_data = 0, crc_out_byte;
   logic [15:0] crc_value, link_crc;
   int fail_count = 0, total_checks = 0;
   always #20 clk = ~clk;
   mrc_engine dut (
      .clk(clk),
      .arst_n(arst_n),
      .rtu_mode(rtu_mode),
      .pkt_start(pkt_start),
      .range_first(range_first),
      .range_last(range_last),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .pkt_end(pkt_end),
      .rx_mode(rx_mode),
      .crc_emit(crc_emit),
      .byte_ready(byte_ready),
      .crc_value(crc_value),
      .crc_out_valid(crc_out_valid),
      .crc_out_byte(crc_out_byte),
      .check_done(check_done),
      .check_err(check_err)
   );
   mrc_link_model link (
      .clk(clk),
      .arst_n(arst_n),
      .crc_out_valid(crc_out_valid),
      .crc_out_byte(crc_out_byte),
      .link_crc(link_crc)
   );
   task tick(); @(posedge clk); #1; endtask
   task chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run();
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task wait_rdy();
      for (int n = 0; byte_ready !== 1'b1; n++) begin
         if (n > 20) begin
            fail_count++;
            $display("[ERR] %0t byte_ready timeout", $time);
            complete_run();
         end
         tick();
      end
   endtask
   // Byte held for one edge once ready is high, then ready awaited again
   task send(input logic [7:0] b);
      wait_rdy();
      byte_valid = 1;
      byte_data = b;
      tick();
      byte_valid = 0;
      tick();
      wait_rdy();
   endtask
   task start(input logic m, rx, input logic [7:0] f, l);
      rtu_mode = m;
      rx_mode = rx;
      range_first = f;
      range_last = l;
      pkt_start = 1;
      tick();
      pkt_start = 0;
      tick();
   endtask
   task t_tx();
      start(1, 0, 0, 1);
      send(8'h02);
      send(8'h07);
      chk(crc_value, 16'h1241);
      crc_emit = 1;
      tick();
      crc_emit = 0;
      repeat (4) tick();
      chk(link_crc, 16'h1241);
   endtask
   // Bytes outside the window on both sides
   task t_range();
      start(1, 0, 1, 2);
      send(8'h02);
      send(8'h02);
      send(8'h07);
      send(8'h55);
      chk(crc_value, 16'h1241);
   endtask
   // Right order, then swapped check bytes
   task t_rx();
      for (int i = 0; i < 2; i++) begin
         start(1, 1, 0, 1);
         send(8'h02);
         send(8'h07);
         send(i ? 8'h12 : 8'h41);
         send(i ? 8'h41 : 8'h12);
         pkt_end = 1;
         tick();
         pkt_end = 0;
         chk({14'h0000, check_done, check_err}, {14'h0000, 1'b1, i[0]});
         tick();
         chk({14'h0000, check_done, check_err}, {14'h0000, 1'b0, i[0]});
      end
   endtask
   task t_off();
      start(0, 0, 0, 1);
      send(8'h02);
      chk(crc_value, 16'hFFFF);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 arst_n = 1;
      tick();
      t_tx();
      t_range();
      t_rx();
      t_off();
      complete_run();
   end
endmodule
